// ### rtl/sdbpc_colgen.sv
// Burst column address generator for sequential and interleaved order.
`timescale 1ns/10ps
`include "sdbpc_params.svh"
module sdbpc_colgen
    import sdbpc_pkg::*;
#(
    parameter int COL_W = 9
) (
    // Burst setup
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [COL_W-1:0] beat,
    input  wire sdbpc_mode_t      mode,
    // Result
    output logic      [COL_W-1:0] col
);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] sum;

    always_comb begin
        unique case (mode.burst_length_setting)
            `SDBPC_BL_2:    mask = COL_W'(1);
            `SDBPC_BL_4:    mask = COL_W'(3);
            `SDBPC_BL_8:    mask = COL_W'(7);
            `SDBPC_BL_PAGE: mask = '1;
            default:        mask = '0;
        endcase
        sum = start_col + beat;
        if (mode.interleave && mode.burst_length_setting != `SDBPC_BL_PAGE) begin
            col = (start_col & ~mask) | ((start_col ^ beat) & mask);
        end else begin
            col = (start_col & ~mask) | (sum & mask);
        end
    end
endmodule

// ### rtl/sdbpc_core.sv
// Command decode, burst control, precharge and power control of a four-bank SDRAM.
`timescale 1ns/10ps
`include "sdbpc_params.svh"
module sdbpc_core
    import sdbpc_pkg::*;
#(
    parameter int COL_W  = 9,
    parameter int DATA_W = 8,
    parameter int DEPTH  = `SDBPC_FIFO_DEPTH
) (
    // Clocking
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // Command pins
    input  wire sdbpc_pins_t       pins,
    input  wire logic [1:0]        bank_sel,
    input  wire logic              dqm,
    // Mode setting
    input  wire sdbpc_mode_t       mode,
    // Data pins
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    input  wire logic [DATA_W-1:0] rd_data,
    // Array write port
    output logic                   arr_wr_valid,
    input  wire logic              arr_wr_ready,
    output logic      [DATA_W-1:0] arr_wr_data,
    output logic      [COL_W-1:0]  col_addr,
    output logic                   col_valid,
    output logic                   fifo_in_ready,
    // Status
    output logic      [3:0]        bank_precharge,
    output logic                   self_refresh,
    output logic                   power_down,
    output logic                   write_active,
    output logic                   read_active
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} sdbpc_burst_t;

    sdbpc_cmd_t       cmd;
    sdbpc_burst_t     state;
    sdbpc_burst_t     next_state;
    logic [COL_W-1:0] start_col;
    logic [COL_W-1:0] next_start_col;
    logic [COL_W-1:0] beat;
    logic [COL_W-1:0] next_beat;
    logic             ap;
    logic             next_ap;
    logic [1:0]       bank;
    logic [1:0]       next_bank;
    logic [3:0]       drain;
    logic [3:0]       next_drain;
    logic [3:0]       next_bank_precharge;
    logic             next_self_refresh;
    logic             next_power_down;
    logic             next_dq_oe;
    logic [DATA_W-1:0] next_dq_out;
    logic [COL_W-1:0] col_now;
    logic             last_beat;
    logic             wr_take;
    logic             flush;
    logic             gated;

    function automatic logic [COL_W-1:0] beats_of(input logic [2:0] bl);
        unique case (bl)
            `SDBPC_BL_2: beats_of = COL_W'(2);
            `SDBPC_BL_4: beats_of = COL_W'(4);
            `SDBPC_BL_8: beats_of = COL_W'(8);
            `SDBPC_BL_PAGE: beats_of = '0;
            default: beats_of = COL_W'(1);
        endcase
    endfunction

    function automatic sdbpc_cmd_t decode(input sdbpc_pins_t p);
        if (p.cs_n) begin
            decode = SDBPC_CMD_DESEL;
        end else begin
            unique case ({p.ras_n, p.cas_n, p.we_n})
                3'h7: decode = SDBPC_CMD_NOP;
                3'h6: decode = SDBPC_CMD_BST;
                3'h5: decode = SDBPC_CMD_READ;
                3'h4: decode = SDBPC_CMD_WRITE;
                3'h2: decode = SDBPC_CMD_PRE;
                3'h1: decode = p.cke ? SDBPC_CMD_OTHER : SDBPC_CMD_SREF;
                default: decode = SDBPC_CMD_OTHER;
            endcase
        end
    endfunction

    // Inputs other than cke are ignored while the receivers are gated.
    assign gated = self_refresh || power_down;
    assign cmd   = gated ? SDBPC_CMD_NOP : decode(pins);

    sdbpc_colgen #(
        .COL_W (COL_W)
    ) u_colgen (
        .start_col (start_col),
        .beat      (beat),
        .mode      (mode),
        .col       (col_now)
    );

    assign last_beat = (mode.burst_length_setting != `SDBPC_BL_PAGE) &&
                       (beat == beats_of(mode.burst_length_setting) - COL_W'(1));
    assign col_addr  = col_now;
    assign col_valid = (state != ST_IDLE);
    assign write_active = (state == ST_WRITE);
    assign read_active  = (state == ST_READ);

    // Write beats enter the FIFO only while a write burst is running.
    assign wr_take = !gated && (state == ST_WRITE) && !dqm &&
                     !(cmd == SDBPC_CMD_READ || cmd == SDBPC_CMD_BST || cmd == SDBPC_CMD_WRITE);
    assign flush   = 1'b0;

    sdbpc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .ce        (ce),
        .flush     (flush),
        .in_valid  (wr_take),
        .in_ready  (fifo_in_ready),
        .in_data   (dq_in),
        .out_valid (arr_wr_valid),
        .out_ready (arr_wr_ready),
        .out_data  (arr_wr_data)
    );

    always_comb begin
        next_state          = state;
        next_start_col      = start_col;
        next_beat           = beat;
        next_ap             = ap;
        next_bank           = bank;
        next_bank_precharge = 4'h0;
        next_self_refresh   = self_refresh;
        next_power_down     = power_down;
        next_drain          = (drain != 4'h0) ? drain - 4'h1 : 4'h0;
        next_dq_oe          = (drain > 4'h1) || (state == ST_READ);
        next_dq_out         = rd_data;
        if (state != ST_IDLE && fifo_in_ready) begin
            next_beat = beat + COL_W'(1);
            if (last_beat) begin
                next_state = ST_IDLE;
                if (ap && state == ST_WRITE) begin
                    next_bank_precharge[bank] = 1'b1;
                end
                if (state == ST_READ) begin
                    next_drain = {2'h0, mode.cas_latency};
                end
            end
        end
        // Read auto-precharge fires CAS latency beats before the last beat.
        if (state == ST_READ && ap &&
            beat == beats_of(mode.burst_length_setting) - COL_W'(1) - COL_W'(mode.cas_latency)) begin
            next_bank_precharge[bank] = 1'b1;
        end
        if (self_refresh) begin
            next_self_refresh = !pins.cke;
        end else if (power_down) begin
            next_power_down = !pins.cke;
        end else begin
            unique case (cmd)
                SDBPC_CMD_READ, SDBPC_CMD_WRITE: begin
                    if (state == ST_READ && cmd == SDBPC_CMD_WRITE) begin
                        next_drain = 4'h0;
                    end
                    next_state     = (cmd == SDBPC_CMD_READ) ? ST_READ : ST_WRITE;
                    next_start_col = pins.addr[COL_W-1:0];
                    next_beat      = (cmd == SDBPC_CMD_WRITE) ? COL_W'(1) : '0;
                    next_ap        = pins.addr[`SDBPC_AP_BIT];
                    next_bank      = bank_sel;
                    if (cmd == SDBPC_CMD_WRITE && beats_of(mode.burst_length_setting) == COL_W'(1)) begin
                        next_state = ST_IDLE;
                        if (pins.addr[`SDBPC_AP_BIT]) begin
                            next_bank_precharge[bank_sel] = 1'b1;
                        end
                    end
                end
                SDBPC_CMD_BST: begin
                    if (state == ST_READ) begin
                        next_drain = {2'h0, mode.cas_latency};
                    end
                    next_state = ST_IDLE;
                end
                SDBPC_CMD_PRE: begin
                    if (pins.addr[`SDBPC_ALLBANK_BIT]) begin
                        next_bank_precharge = 4'hf;
                    end else begin
                        next_bank_precharge[{pins.addr[`SDBPC_BANKHI_BIT], pins.addr[`SDBPC_BANKLO_BIT]}] = 1'b1;
                    end
                end
                SDBPC_CMD_SREF: begin
                    next_self_refresh = 1'b1;
                end
                default: begin
                    if (!pins.cke && state == ST_IDLE) begin
                        next_power_down = 1'b1;
                    end
                end
            endcase
        end
        if (next_state == ST_READ) begin
            next_dq_oe = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state          <= ST_IDLE;
            start_col      <= '0;
            beat           <= '0;
            ap             <= 1'b0;
            bank           <= 2'h0;
            drain          <= 4'h0;
            bank_precharge <= 4'h0;
            self_refresh   <= 1'b0;
            power_down     <= 1'b0;
            dq_oe          <= 1'b0;
            dq_out         <= '0;
        end else if (ce) begin
            state          <= next_state;
            start_col      <= next_start_col;
            beat           <= next_beat;
            ap             <= next_ap;
            bank           <= next_bank;
            drain          <= next_drain;
            bank_precharge <= next_bank_precharge;
            self_refresh   <= next_self_refresh;
            power_down     <= next_power_down;
            dq_oe          <= next_dq_oe;
            dq_out         <= next_dq_out;
        end
    end

    sequence s_bst_read;
        ce && state == ST_READ && cmd == SDBPC_CMD_BST;
    endsequence

    property p_bst_decode;
        @(posedge ref_clk) disable iff (srst)
        (!gated && !pins.cs_n && pins.ras_n && pins.cas_n && !pins.we_n) |-> cmd == SDBPC_CMD_BST;
    endproperty
    a_bst_decode: assert property (p_bst_decode) else $error("Burst stop not decoded.");

    property p_pre_decode;
        @(posedge ref_clk) disable iff (srst)
        (!gated && !pins.cs_n && !pins.ras_n && pins.cas_n && !pins.we_n) |-> cmd == SDBPC_CMD_PRE;
    endproperty
    a_pre_decode: assert property (p_pre_decode) else $error("Precharge not decoded.");

    property p_read_ends_write;
        @(posedge ref_clk) disable iff (srst)
        (ce && state == ST_WRITE && cmd == SDBPC_CMD_READ) |=> state == ST_READ && beat == '0;
    endproperty
    a_read_ends_write: assert property (p_read_ends_write) else $error("Read did not end write.");

    property p_write_restart;
        @(posedge ref_clk) disable iff (srst)
        (ce && state == ST_WRITE && cmd == SDBPC_CMD_WRITE && mode.burst_length_setting != `SDBPC_BL_1)
            |=> state == ST_WRITE && beat == COL_W'(1) && start_col == $past(pins.addr[COL_W-1:0]);
    endproperty
    a_write_restart: assert property (p_write_restart) else $error("Write did not restart.");

    property p_bst_drain;
        @(posedge ref_clk) disable iff (srst)
        (s_bst_read and mode.cas_latency == 2'h2) ##1 ce |=> dq_oe;
    endproperty
    a_bst_drain: assert property (p_bst_drain) else $error("Output released early.");

    property p_bst_write_ignored;
        @(posedge ref_clk) disable iff (srst)
        (ce && state == ST_WRITE && cmd == SDBPC_CMD_BST) |=> !wr_take [*2];
    endproperty
    a_bst_write_ignored: assert property (p_bst_write_ignored) else $error("Write data after stop.");

    property p_nop_keeps;
        @(posedge ref_clk) disable iff (srst)
        (ce && state != ST_IDLE && cmd == SDBPC_CMD_NOP && !last_beat && fifo_in_ready) |=> state == $past(state);
    endproperty
    a_nop_keeps: assert property (p_nop_keeps) else $error("No-operation ended a burst.");

    property p_all_precharge;
        @(posedge ref_clk) disable iff (srst)
        (ce && cmd == SDBPC_CMD_PRE && pins.addr[`SDBPC_ALLBANK_BIT]) |=> bank_precharge == 4'hf;
    endproperty
    a_all_precharge: assert property (p_all_precharge) else $error("All-bank precharge missing.");

    property p_sref_entry;
        @(posedge ref_clk) disable iff (srst)
        (ce && cmd == SDBPC_CMD_SREF) |=> self_refresh;
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("Self refresh not entered.");

    property p_sref_exit;
        @(posedge ref_clk) disable iff (srst)
        (ce && self_refresh && pins.cke) |=> !self_refresh && state == $past(state);
    endproperty
    a_sref_exit: assert property (p_sref_exit) else $error("Self refresh exit wrong.");

    property p_ap_write;
        @(posedge ref_clk) disable iff (srst)
        (ce && state == ST_WRITE && ap && last_beat && fifo_in_ready && cmd == SDBPC_CMD_NOP)
            |=> bank_precharge[$past(bank)];
    endproperty
    a_ap_write: assert property (p_ap_write) else $error("Write auto-precharge late.");
endmodule

// ### rtl/sdbpc_fifo.sv
// Synchronous FIFO for write data with valid and ready on both sides.
`timescale 1ns/10ps
module sdbpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clocking
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            if (push && !flush) begin
                mem[wr_ptr] <= in_data;
            end
        end
    end
endmodule

// ### rtl/sdbpc_params.svh
// Constants for the burst, precharge and power control block.
`ifndef SDBPC_PARAMS_SVH
`define SDBPC_PARAMS_SVH
`define SDBPC_AP_BIT        10
`define SDBPC_ALLBANK_BIT   10
`define SDBPC_BANKLO_BIT    12
`define SDBPC_BANKHI_BIT    13
`define SDBPC_BL_1          3'h0
`define SDBPC_BL_2          3'h1
`define SDBPC_BL_4          3'h2
`define SDBPC_BL_8          3'h3
`define SDBPC_BL_PAGE       3'h7
`define SDBPC_FIFO_DEPTH    8
`define SDBPC_CL_RESET      2'h2
`endif

// ### rtl/sdbpc_pkg.sv
// Types for the burst, precharge and power control block.
package sdbpc_pkg;
    typedef enum logic [2:0] {
        SDBPC_CMD_NOP,
        SDBPC_CMD_DESEL,
        SDBPC_CMD_READ,
        SDBPC_CMD_WRITE,
        SDBPC_CMD_PRE,
        SDBPC_CMD_BST,
        SDBPC_CMD_SREF,
        SDBPC_CMD_OTHER
    } sdbpc_cmd_t;

    typedef struct packed {
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        cke;
        logic [13:0] addr;
    } sdbpc_pins_t;

    typedef struct packed {
        logic [2:0] burst_length_setting;
        logic       interleave;
        logic [1:0] cas_latency;
    } sdbpc_mode_t;
endpackage

// ### test/sdbpc_ctrl_model.sv
// Memory controller model driving command, address, mask and write data pins.
`timescale 1ns/10ps
module sdbpc_ctrl_model
    import sdbpc_pkg::*;
(
    // Clock
    input  wire logic   ref_clk,
    // Command and data pins
    output sdbpc_pins_t pins,
    output logic [1:0]  bank_sel,
    output logic        dqm,
    output logic [7:0]  dq_in
);
    initial begin
        pins     = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 14'h0};
        bank_sel = 2'h0;
        dqm      = 1'h0;
        dq_in    = 8'h0;
    end

    // It never issues an activate, so bank reopening delays are never cut short.
    task automatic issue(input sdbpc_cmd_t c, input logic [13:0] a, input logic [7:0] d, input logic wd,
                         input logic k);
        logic [3:0] p;
        case (c)
            SDBPC_CMD_READ:  p = 4'h5;
            SDBPC_CMD_WRITE: p = 4'h4;
            SDBPC_CMD_PRE:   p = 4'h2;
            SDBPC_CMD_BST:   p = 4'h6;
            SDBPC_CMD_SREF:  p = 4'h1;
            SDBPC_CMD_DESEL: p = 4'hf;
            default:         p = 4'h7;
        endcase
        @(negedge ref_clk);
        {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = p;
        pins.cke  = k;
        pins.addr = a;
        bank_sel  = a[13:12];
        // Released data lines show the inverse of the last value.
        dq_in     = wd ? d : ~dq_in;
        #1;
    endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the burst, precharge and power control block.
`timescale 1ns/10ps
module testbench
    import sdbpc_pkg::*;
;
    logic        ref_clk;
    logic        srst;
    logic        ce;
    sdbpc_pins_t pins;
    logic [1:0]  bank_sel;
    logic        dqm;
    logic [7:0]  dq_in;
    sdbpc_mode_t mode;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic [7:0]  rd_data;
    logic        arr_wr_valid;
    logic        arr_wr_ready;
    logic [7:0]  arr_wr_data;
    logic [8:0]  col_addr;
    logic        col_valid;
    logic        fifo_in_ready;
    logic [3:0]  bank_precharge;
    logic        self_refresh;
    logic        power_down;
    logic        write_active;
    logic        read_active;
    int          mismatches = 0;
    int          compares = 0;
    int          drained = 0;
    logic [7:0]  exp_wr = 8'h1;

    assign rd_data = col_addr[7:0] ^ 8'h3c;

    sdbpc_core i_sdbpc_core (
        .ref_clk(ref_clk), .srst(srst), .ce(ce), .pins(pins), .bank_sel(bank_sel), .dqm(dqm), .mode(mode),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rd_data(rd_data), .arr_wr_valid(arr_wr_valid),
        .arr_wr_ready(arr_wr_ready), .arr_wr_data(arr_wr_data), .col_addr(col_addr), .col_valid(col_valid),
        .fifo_in_ready(fifo_in_ready), .bank_precharge(bank_precharge), .self_refresh(self_refresh),
        .power_down(power_down), .write_active(write_active), .read_active(read_active)
    );

    sdbpc_ctrl_model i_sdbpc_ctrl_model (
        .ref_clk(ref_clk), .pins(pins), .bank_sel(bank_sel), .dqm(dqm), .dq_in(dq_in)
    );

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Drained array writes must carry the beats in the order they were presented.
    always @(posedge ref_clk) begin
        if (arr_wr_valid === 1'h1 && arr_wr_ready === 1'h1) begin
            drained++;
            chk_vec(9'(arr_wr_data), 9'(exp_wr), "array write data");
            exp_wr++;
        end
    end

    function automatic logic [8:0] exp_col(input logic [8:0] s, input int k, input int len, input logic il);
        logic [8:0] m;
        m = 9'(len - 1);
        if (il) return (s & ~m) | ((s ^ 9'(k)) & m);
        return (s & ~m) | ((s + 9'(k)) & m);
    endfunction

    task automatic cmd(input sdbpc_cmd_t c, input logic [13:0] a = 14'h0, input logic [7:0] d = 8'h0,
                       input logic wd = 1'h0, input logic k = 1'h1);
        i_sdbpc_ctrl_model.issue(c, a, d, wd, k);
    endtask

    task automatic t_burst(input int code, input logic il, input logic wr, input logic ap, input logic [1:0] cl);
        int         len;
        logic [3:0] seen;
        len = 1 << code;
        seen = 4'h0;
        drained = 0;
        exp_wr = 8'h1;
        mode = '{3'(code), il, cl};
        cmd(wr ? SDBPC_CMD_WRITE : SDBPC_CMD_READ, {2'h2, 1'h0, ap, 1'h0, 9'h0a6});
        // A read shows beat 0 after its command, a write used beat 0 in the command cycle.
        for (int k = 1; k < len + (wr ? 0 : 1); k++) begin
            cmd(SDBPC_CMD_NOP, 14'h0, 8'(k), wr);
            chk_vec(col_addr, exp_col(9'h0a6, wr ? k : k - 1, len, il), "burst column");
            if (!wr && k > 1) begin
                chk_vec(9'(dq_out), 9'(8'(exp_col(9'h0a6, k - 2, len, il)) ^ 8'h3c), "read data");
            end
            seen |= bank_precharge;
        end
        cmd(SDBPC_CMD_NOP);
        chk_bit(wr ? write_active : read_active, 1'h0, "burst end");
        chk_bit(col_valid, 1'h0, "column idle");
        if (ap && !wr) chk_vec(9'(seen), 9'h004, "read precharge start");
        if (ap && wr) chk_vec(9'({seen, bank_precharge}), 9'h004, "write precharge start");
        repeat (2) cmd(SDBPC_CMD_NOP);
        if (wr) chk_vec(9'(drained), 9'(len - 1), "beats written");
    endtask

    task automatic t_interrupts();
        mode = '{3'h2, 1'h0, 2'h2};
        drained = 0;
        exp_wr = 8'h1;
        cmd(SDBPC_CMD_WRITE);
        cmd(SDBPC_CMD_NOP, 14'h0, 8'h1, 1'h1);
        cmd(SDBPC_CMD_WRITE, 14'h010);
        for (int k = 1; k < 4; k++) begin
            cmd(SDBPC_CMD_NOP, 14'h0, 8'(k + 1), 1'h1);
            chk_vec(col_addr, 9'h010 + 9'(k), "restarted column");
        end
        cmd(SDBPC_CMD_NOP);
        chk_bit(write_active, 1'h0, "restarted length");
        mode = '{3'h3, 1'h0, 2'h2};
        cmd(SDBPC_CMD_WRITE);
        cmd(SDBPC_CMD_NOP, 14'h0, 8'h5, 1'h1);
        cmd(SDBPC_CMD_READ, 14'h020, 8'h77, 1'h1);
        cmd(SDBPC_CMD_NOP, 14'h0, 8'h78, 1'h1);
        chk_bit(write_active, 1'h0, "write cut by read");
        chk_bit(read_active, 1'h1, "read started");
        chk_vec(col_addr, 9'h020, "read column");
        repeat (10) cmd(SDBPC_CMD_NOP);
        chk_vec(9'(drained), 9'h005, "residual beats dropped");
    endtask

    task automatic t_page();
        mode = '{3'h7, 1'h0, 2'h2};
        cmd(SDBPC_CMD_READ, 14'h1ff);
        cmd(SDBPC_CMD_NOP);
        chk_vec(col_addr, 9'h1ff, "page column");
        chk_bit(col_valid, 1'h1, "column valid");
        cmd(SDBPC_CMD_NOP);
        chk_vec(col_addr, 9'h000, "page wrap");
        cmd(SDBPC_CMD_BST);
        cmd(SDBPC_CMD_NOP);
        chk_bit(read_active, 1'h0, "read stopped");
        chk_bit(dq_oe, 1'h1, "output held");
        repeat (2) cmd(SDBPC_CMD_NOP);
        chk_bit(dq_oe, 1'h0, "output released");
        arr_wr_ready = 1'h0;
        drained = 0;
        exp_wr = 8'h1;
        cmd(SDBPC_CMD_WRITE);
        for (int k = 1; k < 9; k++) cmd(SDBPC_CMD_NOP, 14'h0, 8'(k), 1'h1);
        cmd(SDBPC_CMD_BST, 14'h0, 8'h99, 1'h1);
        chk_bit(fifo_in_ready, 1'h0, "buffer full");
        arr_wr_ready = 1'h1;
        repeat (12) cmd(SDBPC_CMD_NOP, 14'h0, 8'h99, 1'h1);
        chk_bit(write_active, 1'h0, "write stopped");
        chk_vec(9'(drained), 9'h008, "beats after stop");
        chk_bit(arr_wr_valid, 1'h0, "buffer empty");
    endtask

    task automatic t_precharge();
        for (int b = 0; b < 4; b++) begin
            cmd(SDBPC_CMD_PRE, {2'(b), 12'h0});
            cmd(SDBPC_CMD_NOP);
            chk_vec(9'(bank_precharge), 9'(4'h1 << b), "single bank");
        end
        cmd(SDBPC_CMD_PRE, 14'h1400);
        cmd(SDBPC_CMD_NOP);
        chk_vec(9'(bank_precharge), 9'h00f, "all banks");
    endtask

    task automatic t_low_power();
        cmd(SDBPC_CMD_SREF, 14'h0, 8'h0, 1'h0, 1'h0);
        cmd(SDBPC_CMD_NOP, 14'h0, 8'h0, 1'h0, 1'h0);
        chk_bit(self_refresh, 1'h1, "self refresh entry");
        cmd(SDBPC_CMD_PRE, 14'h0400, 8'h0, 1'h0, 1'h0);
        cmd(SDBPC_CMD_NOP, 14'h0, 8'h0, 1'h0, 1'h0);
        chk_vec(9'(bank_precharge), 9'h000, "ignored in self refresh");
        for (int i = 0; i < 4 && self_refresh !== 1'h0; i++) cmd(SDBPC_CMD_NOP);
        chk_bit(self_refresh, 1'h0, "self refresh exit");
        cmd(SDBPC_CMD_DESEL, 14'h0, 8'h0, 1'h0, 1'h0);
        cmd(SDBPC_CMD_DESEL, 14'h0, 8'h0, 1'h0, 1'h0);
        chk_bit(power_down, 1'h1, "power down entry");
        cmd(SDBPC_CMD_PRE, 14'h0400, 8'h0, 1'h0, 1'h0);
        cmd(SDBPC_CMD_DESEL, 14'h0, 8'h0, 1'h0, 1'h0);
        chk_vec(9'(bank_precharge), 9'h000, "ignored in power down");
        for (int i = 0; i < 4 && power_down !== 1'h0; i++) cmd(SDBPC_CMD_NOP);
        chk_bit(power_down, 1'h0, "power down exit");
        cmd(SDBPC_CMD_PRE, 14'h0400);
        cmd(SDBPC_CMD_NOP);
        chk_vec(9'(bank_precharge), 9'h00f, "commands after exit");
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end

    initial begin
        srst = 1'h1;
        ce = 1'h1;
        arr_wr_ready = 1'h1;
        mode = '{3'h2, 1'h0, 2'h2};
        repeat (3) @(negedge ref_clk);
        srst = 1'h0;
        for (int c = 1; c < 4; c++) begin
            t_burst(c, 1'h0, 1'h0, 1'h0, 2'h2);
            t_burst(c, 1'h1, 1'h0, 1'h0, 2'h2);
        end
        t_burst(2, 1'h0, 1'h1, 1'h1, 2'h2);
        t_burst(3, 1'h1, 1'h1, 1'h0, 2'h2);
        t_burst(2, 1'h0, 1'h0, 1'h1, 2'h2);
        t_burst(3, 1'h1, 1'h0, 1'h1, 2'h3);
        t_interrupts();
        t_page();
        t_precharge();
        t_low_power();
        complete_run();
    end
endmodule
